/* File: smsl_pkg.sv */
package smsl_pkg;

  localparam int unsigned CLK_MHZ       = 200;
  localparam int unsigned T_LOW_NS      = 500;
  localparam int unsigned T_DELAY_NS    = 1000;
  localparam int unsigned T_FAST_NS     = 63;
  // Least times round up, longest times round down
  localparam int unsigned LOW_CYC       = (T_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DELAY_CYC     = (T_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FAST_CYC      = (T_FAST_NS * CLK_MHZ) / 1000;
  localparam int unsigned SAMPLE_DIV    = 1024;
  localparam int unsigned CNT_W         = 12;
  localparam logic [CNT_W-1:0] CNT_RST  = 12'h000;
  localparam logic [3:0] RATE_RST       = 4'h0;

  typedef enum logic [3:0] {
    SMSL_MODE_NORMAL,
    SMSL_MODE_RT_INTEG,
    SMSL_MODE_RT_STORE,
    SMSL_MODE_WIDE_HARM,
    SMSL_MODE_IEC_HARM,
    SMSL_MODE_WAVE_COMP,
    SMSL_MODE_FFT,
    SMSL_MODE_FLICKER,
    SMSL_MODE_CYCLE
  } smsl_mode_t;

  // Synchronization is allowed only in normal mode with matching rates
  function automatic logic sync_ok(input smsl_mode_t mode, input logic [3:0] rate,
                                   input logic [3:0] peer_rate);
    sync_ok = (mode == SMSL_MODE_NORMAL) && (rate == peer_rate);
  endfunction

  // Sample divider step: returns next count
  function automatic logic [CNT_W-1:0] div_next(input logic [CNT_W-1:0] cnt,
                                                input logic [CNT_W-1:0] div);
    div_next = (cnt >= div - 12'h001) ? CNT_RST : cnt + 12'h001;
  endfunction

endpackage

/* File: smsl_if.sv */
`timescale 1ns/100ps
// Start line between the two instruments, pulled high when undriven
interface smsl_if;
  logic start_out;  // Master drive level
  logic start_oe;   // Master drives the line
  logic start_n;    // Resolved line level

  assign start_n = start_oe ? start_out : 1'b1;

  modport master (output start_out, output start_oe, input start_n);
  modport slave  (input start_n);
endinterface

/* File: smsl_master.sv */
`timescale 1ns/100ps
module smsl_master #(
  parameter int unsigned SAMPLE_DIV = smsl_pkg::SAMPLE_DIV
) (
  input  wire logic               CLK_SYS,       // 200 MHz clock
  input  wire logic               RST,           // Async reset, high
  smsl_if.master                  LNK,           // Start line
  input  wire logic               SYNC_EN,       // Configured as master
  input  wire smsl_pkg::smsl_mode_t MODE,        // Measurement mode
  input  wire logic [3:0]         UPD_RATE,      // Own update rate code
  input  wire logic [3:0]         PEER_RATE,     // Slave update rate code
  input  wire logic               MEAS_START,    // Start request pulse
  input  wire logic               MEAS_STOP,     // Stop request pulse
  input  wire logic               HOLD_ON_REQ,   // Hold on request pulse
  input  wire logic               HOLD_OFF_REQ,  // Hold off request pulse
  output logic                    MEAS_RUN,      // Own measurement running
  output logic                    HOLD_SET,      // Hold engage pulse
  output logic                    SYNC_REFUSED   // Sync refused level
);
  typedef enum logic [1:0] {ST_IDLE, ST_DLY, ST_SMP, ST_RUN} smsl_mst_t;

  smsl_mst_t               st_r, st_nxt;
  logic [smsl_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [smsl_pkg::CNT_W-1:0] div_r, div_nxt;
  logic                    role_r, role_nxt;
  logic                    ok_r, ok_nxt;
  logic                    drv_r, drv_nxt;
  logic                    run_r, run_nxt;
  logic                    hset_r, hset_nxt;
  logic                    refd_r, refd_nxt;
  logic                    tick;

  assign tick = (div_r == smsl_pkg::CNT_RST);

  // Next state: divider, role, start sequence, hold
  always_comb begin
    div_nxt  = smsl_pkg::div_next(div_r, SAMPLE_DIV[smsl_pkg::CNT_W-1:0]);
    role_nxt = SYNC_EN;
    ok_nxt   = smsl_pkg::sync_ok(MODE, UPD_RATE, PEER_RATE);
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    drv_nxt  = drv_r;
    run_nxt  = run_r;
    hset_nxt = role_r && HOLD_ON_REQ;
    refd_nxt = role_nxt && !ok_nxt;
    unique case (st_r)
      ST_IDLE: begin
        drv_nxt = 1'b0;
        run_nxt = 1'b0;
        if (MEAS_START) begin
          cnt_nxt = smsl_pkg::CNT_RST;
          st_nxt  = ST_DLY;
          drv_nxt = role_r && ok_r;
        end
      end
      ST_DLY: begin
        cnt_nxt = cnt_r + 12'h001;
        if (cnt_r == smsl_pkg::DELAY_CYC[smsl_pkg::CNT_W-1:0] - 12'h001) begin
          cnt_nxt = smsl_pkg::CNT_RST;
          st_nxt  = ST_SMP;
        end
      end
      ST_SMP: begin
        cnt_nxt = cnt_r + 12'h001;
        if (cnt_r == SAMPLE_DIV[smsl_pkg::CNT_W-1:0] - 12'h001) begin
          st_nxt  = ST_RUN;
          run_nxt = 1'b1;
        end
      end
      ST_RUN: begin
        if (MEAS_STOP) begin
          st_nxt  = ST_IDLE;
          run_nxt = 1'b0;
          drv_nxt = 1'b0;
        end
      end
    endcase
    if (!role_r && drv_r) begin
      drv_nxt = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_r   <= ST_IDLE;
      cnt_r  <= smsl_pkg::CNT_RST;
      div_r  <= smsl_pkg::CNT_RST;
      role_r <= 1'b0;
      ok_r   <= 1'b0;
      drv_r  <= 1'b0;
      run_r  <= 1'b0;
      hset_r <= 1'b0;
      refd_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      div_r  <= div_nxt;
      role_r <= role_nxt;
      ok_r   <= ok_nxt;
      drv_r  <= drv_nxt;
      run_r  <= run_nxt;
      hset_r <= hset_nxt;
      refd_r <= refd_nxt;
    end
  end

  // Line drives low only while a synchronized start is active
  assign LNK.start_out = 1'b0;
  assign LNK.start_oe  = drv_r;
  assign MEAS_RUN      = run_r;
  assign HOLD_SET      = hset_r;
  assign SYNC_REFUSED  = refd_r;  // Same timing as role and ok registers

  logic unused_ok;
  assign unused_ok = tick ^ HOLD_OFF_REQ ^ LNK.start_n;
endmodule

/* File: smsl_slave.sv */
`timescale 1ns/100ps
module smsl_slave #(
  parameter int unsigned SAMPLE_DIV = smsl_pkg::SAMPLE_DIV
) (
  input  wire logic               CLK_SYS,       // 200 MHz clock
  input  wire logic               RST,           // Async reset, high
  smsl_if.slave                   LNK,           // Start line
  input  wire logic               SYNC_EN,       // Configured as slave
  input  wire smsl_pkg::smsl_mode_t MODE,        // Measurement mode
  input  wire logic [3:0]         UPD_RATE,      // Own update rate code
  input  wire logic [3:0]         PEER_RATE,     // Master update rate code
  input  wire logic               HOLD,          // Hold currently active
  input  wire logic               HOLD_OFF_REQ,  // Hold off request pulse
  output logic                    MEAS_RUN,      // Own measurement running
  output logic                    HOLD_CLR,      // Hold release pulse
  output logic                    PULSE_ERR      // Short pulse seen, pulse
);
  typedef enum logic [1:0] {ST_IDLE, ST_DLY, ST_SMP, ST_RUN} smsl_slv_t;

  smsl_slv_t               st_r, st_nxt;
  logic [smsl_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [smsl_pkg::CNT_W-1:0] wid_r, wid_nxt;
  logic [smsl_pkg::CNT_W-1:0] div_r, div_nxt;
  logic                    s1_r, s2_r, s3_r;
  logic                    role_r, ok_r, hold_r;
  logic                    run_r, run_nxt;
  logic                    hclr_r, hclr_nxt;
  logic                    err_r, err_nxt;
  logic                    fall, rise, tick, wide;

  // Second stage feeds the edge detector; first stage feeds nothing else
  assign fall = s3_r && !s2_r;
  assign rise = !s3_r && s2_r;
  assign tick = (div_r == smsl_pkg::CNT_RST);
  assign wide = (wid_r >= smsl_pkg::LOW_CYC[smsl_pkg::CNT_W-1:0]);

  // Next state: divider, width check, start delay, stop
  always_comb begin
    div_nxt  = smsl_pkg::div_next(div_r, SAMPLE_DIV[smsl_pkg::CNT_W-1:0]);
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    err_nxt  = 1'b0;
    hclr_nxt = role_r && HOLD_OFF_REQ;
    wid_nxt  = (!s2_r && !wide) ? wid_r + 12'h001 : wid_r;
    unique case (st_r)
      ST_IDLE: begin
        run_nxt = 1'b0;
        if (fall && role_r && ok_r) begin
          wid_nxt = 12'h001;
          cnt_nxt = smsl_pkg::CNT_RST;
          st_nxt  = hold_r ? ST_DLY : ST_SMP;
        end
      end
      ST_DLY: begin
        cnt_nxt = cnt_r + 12'h001;
        if (cnt_r == smsl_pkg::DELAY_CYC[smsl_pkg::CNT_W-1:0] - 12'h001) begin
          cnt_nxt = smsl_pkg::CNT_RST;
          st_nxt  = ST_SMP;
        end
      end
      ST_SMP: begin
        cnt_nxt = cnt_r + 12'h001;
        if (hold_r ? (cnt_r == SAMPLE_DIV[smsl_pkg::CNT_W-1:0] - 12'h001) : tick) begin
          st_nxt  = ST_RUN;
          run_nxt = 1'b1;
        end
      end
      ST_RUN: begin
        if (rise) begin
          st_nxt  = ST_IDLE;
          run_nxt = 1'b0;
        end
      end
    endcase
    // A low pulse shorter than the minimum cancels the pending start
    if (rise && !wide && st_r != ST_IDLE) begin
      st_nxt  = ST_IDLE;
      run_nxt = 1'b0;
      err_nxt = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_r   <= ST_IDLE;
      cnt_r  <= smsl_pkg::CNT_RST;
      wid_r  <= smsl_pkg::CNT_RST;
      div_r  <= smsl_pkg::CNT_RST;
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      s3_r   <= 1'b1;
      role_r <= 1'b0;
      ok_r   <= 1'b0;
      hold_r <= 1'b0;
      run_r  <= 1'b0;
      hclr_r <= 1'b0;
      err_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wid_r  <= wid_nxt;
      div_r  <= div_nxt;
      s1_r   <= LNK.start_n;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      role_r <= SYNC_EN;
      ok_r   <= smsl_pkg::sync_ok(MODE, UPD_RATE, PEER_RATE);
      hold_r <= HOLD;
      run_r  <= run_nxt;
      hclr_r <= hclr_nxt;
      err_r  <= err_nxt;
    end
  end

  assign MEAS_RUN  = run_r;
  assign HOLD_CLR  = hclr_r;
  assign PULSE_ERR = err_r;
endmodule

/* File: smsl_properties.sv */
`timescale 1ns/100ps
module smsl_properties (
  input wire logic CLK_SYS,    // System clock
  input wire logic RST,        // Async reset, high
  input wire logic start_out,  // Master drive level
  input wire logic start_oe,   // Master drives line
  input wire logic start_n     // Resolved line level
);
  logic [11:0] low_cnt_r;    // Cycles line driven
  logic [11:0] low_cnt_nxt;  // Next driven count

  // Count driven cycles, saturating
  always_comb begin
    low_cnt_nxt = !start_oe ? 12'h000 : (&low_cnt_r ? low_cnt_r : low_cnt_r + 12'h001);
  end

  // Register the count
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      low_cnt_r <= 12'h000;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Line behaviour while and after driving
  a_drive_level_low: assert property (start_oe |-> !start_out)
    else $error("start line driven high");
  a_line_follows_drive: assert property (start_oe |-> !start_n)
    else $error("driven line not low");
  a_released_line_high: assert property (!start_oe |-> start_n)
    else $error("released line not high");
  a_start_is_fall: assert property ($rose(start_oe) |-> $fell(start_n))
    else $error("drive without falling edge");
  a_fall_needs_drive: assert property ($fell(start_n) |-> $rose(start_oe))
    else $error("falling edge without new drive");
  a_low_hold_min: assert property ($fell(start_oe) |-> low_cnt_r >= smsl_pkg::LOW_CYC)
    else $error("low pulse too short");
  a_low_short_hold: assert property ($rose(start_oe) |=> start_oe [*8])
    else $error("drive dropped early");
  a_reset_leaves_idle: assert property ($fell(RST) |-> !start_oe ##1 !start_oe)
    else $error("line driven after reset");

  // Main scenarios
  cover property ($rose(start_oe));
  cover property ($fell(start_oe));
  cover property (start_oe && low_cnt_r == 12'h0C8);
endmodule

/* File: sync_measure_start_link_tb.sv */
`timescale 1ns/100ps
module sync_measure_start_link_tb;
  localparam int SD = 16;
  logic                 CLK_SYS, RST, en, start_req, stop_req, hon, hoff, s_hold, drv2;
  logic                 m_run, hold_set, refused, s_run, hold_clr, perr, s2_run, perr2;
  logic [3:0]           m_rate, s_rate;
  smsl_pkg::smsl_mode_t m_mode, s_mode;
  int                   errors = 0, cmp_count = 0, cyc = 0, perr_n = 0;
  smsl_if lnk();
  smsl_if lnk2();
  assign lnk2.start_oe  = drv2;
  assign lnk2.start_out = 1'b0;
  smsl_master #(.SAMPLE_DIV(SD)) smsl_master_i (.CLK_SYS(CLK_SYS), .RST(RST), .LNK(lnk),
    .SYNC_EN(en), .MODE(m_mode), .UPD_RATE(m_rate), .PEER_RATE(s_rate), .MEAS_START(start_req),
    .MEAS_STOP(stop_req), .HOLD_ON_REQ(hon), .HOLD_OFF_REQ(hoff), .MEAS_RUN(m_run),
    .HOLD_SET(hold_set), .SYNC_REFUSED(refused));
  smsl_slave #(.SAMPLE_DIV(SD)) smsl_slave_i (.CLK_SYS(CLK_SYS), .RST(RST), .LNK(lnk),
    .SYNC_EN(en), .MODE(s_mode), .UPD_RATE(s_rate), .PEER_RATE(m_rate), .HOLD(s_hold),
    .HOLD_OFF_REQ(hoff), .MEAS_RUN(s_run), .HOLD_CLR(hold_clr), .PULSE_ERR(perr));
  smsl_slave #(.SAMPLE_DIV(SD)) smsl_slave_i2 (.CLK_SYS(CLK_SYS), .RST(RST), .LNK(lnk2),
    .SYNC_EN(en), .MODE(s_mode), .UPD_RATE(s_rate), .PEER_RATE(m_rate), .HOLD(s_hold),
    .HOLD_OFF_REQ(hoff), .MEAS_RUN(s2_run), .HOLD_CLR(), .PULSE_ERR(perr2));
  smsl_properties smsl_properties_i (.CLK_SYS(CLK_SYS), .RST(RST), .start_out(lnk.start_out),
    .start_oe(lnk.start_oe), .start_n(lnk.start_n));

  // Clock generation
  initial begin
    CLK_SYS = 1'b0;
    forever #2.5 CLK_SYS = ~CLK_SYS;
  end

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Step past edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  // Hold request pulse, count answer pulses
  task automatic pulses(input bit clr, output int n);
    n = 0;
    if (clr) pulse(hoff);
    else pulse(hon);
    repeat (3) begin
      n += ((clr ? hold_clr : hold_set) === 1'b1);
      tick(1);
    end
  endtask

  // Start, record cycles until each side runs
  task automatic run(output int mk, output int sk);
    mk = 0;
    sk = 0;
    pulse(start_req);
    for (int k = 1; k < 400 && (mk == 0 || sk == 0); k++) begin
      tick(1);
      if (m_run === 1'b1 && mk == 0) mk = k;
      if (s_run === 1'b1 && sk == 0) sk = k;
    end
  endtask

  task automatic stop_chk();
    pulse(stop_req);
    tick(6);
    chk({lnk.start_n, m_run, s_run}, 32'h4);
  endtask

  // Hang guard
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      finish_test();
    end
  end

  // Count error pulses of the main slave, sampled away from the launch edge
  always @(negedge CLK_SYS) begin
    if (perr === 1'b1) begin
      perr_n++;
    end
  end

  // Main sequence
  initial begin
    int mk, sk, n;
    RST = 1'b1;
    {en, start_req, stop_req, hon, hoff, s_hold, drv2} = 7'h40;
    m_mode = smsl_pkg::SMSL_MODE_NORMAL;
    s_mode = smsl_pkg::SMSL_MODE_NORMAL;
    m_rate = 4'h3;
    s_rate = 4'h3;
    tick(10);
    RST = 1'b0;
    tick(2);
    chk({lnk.start_n, m_run, s_run, refused}, 32'h8);
    run(mk, sk);
    chk(mk, smsl_pkg::DELAY_CYC + SD);
    chk(sk <= SD + 5, 32'h1);
    stop_chk();
    s_hold = 1'b1;
    run(mk, sk);
    chk(sk >= smsl_pkg::DELAY_CYC + SD + 1 && sk <= smsl_pkg::DELAY_CYC + SD + 8, 32'h1);
    stop_chk();
    s_hold = 1'b0;
    pulses(1'b0, n);
    chk(n, 32'h1);
    pulses(1'b1, n);
    chk(n, 32'h1);
    // Every refusing mode on the master
    for (int m = 1; m < 9; m++) begin
      m_mode = smsl_pkg::smsl_mode_t'(m);
      tick(2);
      chk(refused, 32'h1);
    end
    m_mode = smsl_pkg::SMSL_MODE_NORMAL;
    s_rate = 4'h5;
    tick(2);
    chk(refused, 32'h1);
    run(mk, sk);
    chk({lnk.start_n, sk[0]}, 32'h2);
    stop_chk();
    s_rate = 4'h3;
    s_mode = smsl_pkg::SMSL_MODE_FFT;
    tick(2);
    run(mk, sk);
    chk(sk, 32'h0);
    stop_chk();
    s_mode = smsl_pkg::SMSL_MODE_NORMAL;
    // Short then long pulse on the second line
    drv2 = 1'b1;
    tick(20);
    drv2 = 1'b0;
    n = 0;
    repeat (12) begin
      n += (perr2 === 1'b1);
      tick(1);
    end
    chk({n[3:0], s2_run}, 32'h2);
    drv2 = 1'b1;
    tick(120);
    chk(s2_run, 32'h1);
    drv2 = 1'b0;
    tick(6);
    chk(s2_run, 32'h0);
    en = 1'b0;
    tick(2);
    pulses(1'b1, n);
    chk(n, 32'h0);
    chk(perr_n, 32'h0);
    finish_test();
  end
endmodule
